// ---- inc/stw_pkg.sv ----
// Constants, encodings and carrier types of the stop-mode wake-up source selector
package stw_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] CFG_TWO_IDX  = 8'h0d;
  localparam logic [7:0] PRIM_IDX     = 8'h0b;
  localparam logic [7:0] STAT_IDX     = 8'h0e;
  localparam int         IDX_SHIFT    = 2;

  // Field layout of stop_wakeup_config_two and of the primary register
  localparam int         LEVEL_BIT    = 6;
  localparam int         SRC_LSB      = 2;
  localparam int         SRC_MSB      = 4;
  localparam int         PRIM_LSB     = 2;
  localparam int         PRIM_MSB     = 4;

  // Status word layout
  localparam int         STAT_WAKE    = 0;
  localparam int         STAT_CFG2    = 1;
  localparam int         STAT_PRIM    = 2;

  // Wake-up source codes of the selector
  typedef enum logic [2:0] {
    SRC_POR_ONLY   = 3'b000,
    SRC_NAND_P2LO  = 3'b001,
    SRC_NAND_P2ALL = 3'b010,
    SRC_NOR_P3     = 3'b011,
    SRC_NAND_P3    = 3'b100,
    SRC_NOR_P3P0   = 3'b101,
    SRC_NAND_P3P0  = 3'b110,
    SRC_NAND_P3P2  = 3'b111
  } stw_src_t;

  // Reset values
  localparam stw_src_t   SRC_RST      = SRC_POR_ONLY;
  localparam logic       LEVEL_RST    = 1'b0;
  localparam logic [2:0] PRIM_RST     = 3'h0;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } stw_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } stw_apb_rsp_t;

  // Port pin levels, or per-pin output-direction flags (1 = output)
  typedef struct packed {
    logic [7:0] port2;
    logic [3:1] port3;
    logic       port0bit7;
    logic       port0bit0;
  } stw_pins_t;

endpackage : stw_pkg

// ---- core/stw_pin_gate.sv ----
// NAND and NOR of a group of port pins, ignoring pins driven as outputs
`timescale 1ns/10ps
module stw_pin_gate #(
  parameter int WIDTH = 3
) (
  input  wire logic [WIDTH-1:0] pinLvl,
  input  wire logic [WIDTH-1:0] pinIsOut,
  output logic                  nandOut,
  output logic                  norOut
);
  // Output pins forced to the neutral level of each gate so they never vote
  assign nandOut = ~&(pinLvl | pinIsOut);
  assign norOut  = ~|(pinLvl & ~pinIsOut);
endmodule : stw_pin_gate

// ---- core/stw_wakeup_sel.sv ----
// Stop-mode wake-up source selector with its APB register slave
//
// Functional notes
// - Code 101 NOR P3[3:1],P0[0,7]; 011 NOR P3[3:1]
// - Code 110 NAND P3[3:1],P0[0,7]; 100 NAND P3
// - 111 NAND P3/P2[2:0]; 001 P2[3:0]; 010 P2
// - Reset gives source 000 and level low
// - Level bit 6 XORed with selected source
// - Pins configured as outputs never take part
// - Either this or primary source ends stop
// - Source and level bits are write-only
// - Primary register bits 4..2 select its source
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module stw_wakeup_sel (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire stw_pkg::stw_apb_req_t apbReq,
  output      stw_pkg::stw_apb_rsp_t apbRsp,
  input  wire stw_pkg::stw_pins_t    pinLvl,
  input  wire stw_pkg::stw_pins_t    pinIsOut,
  input  wire logic                  primaryWake,
  output logic [2:0]                 primarySrcSel,
  output logic                       stopWake
);
  import stw_pkg::*;

  // Whole state of the block
  typedef struct packed {
    stw_src_t    src;
    logic        level;
    logic [2:0]  prim;
    logic [1:0]  syncWake;
    logic [1:0]  syncCfg;
    logic [1:0]  syncPrim;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } stw_state_t;

  stw_state_t st_r;
  stw_state_t st_nxt;

  logic nandP3;
  logic norP3;
  logic nandP3P0;
  logic norP3P0;
  logic nandP2Lo;
  logic nandP2All;
  logic nandP3P2;
  logic unusedNor2Lo;
  logic unusedNor2All;
  logic unusedNor3P2;
  logic selComb;
  logic cfgWake;

  // Pin groups for each source combination
  stw_pin_gate #(.WIDTH(3)) uGateP3 (
    .pinLvl   (pinLvl.port3),
    .pinIsOut (pinIsOut.port3),
    .nandOut  (nandP3),
    .norOut   (norP3)
  );

  stw_pin_gate #(.WIDTH(5)) uGateP3P0 (
    .pinLvl   ({pinLvl.port3, pinLvl.port0bit7, pinLvl.port0bit0}),
    .pinIsOut ({pinIsOut.port3, pinIsOut.port0bit7, pinIsOut.port0bit0}),
    .nandOut  (nandP3P0),
    .norOut   (norP3P0)
  );

  stw_pin_gate #(.WIDTH(4)) uGateP2Lo (
    .pinLvl   (pinLvl.port2[3:0]),
    .pinIsOut (pinIsOut.port2[3:0]),
    .nandOut  (nandP2Lo),
    .norOut   (unusedNor2Lo)
  );

  stw_pin_gate #(.WIDTH(8)) uGateP2All (
    .pinLvl   (pinLvl.port2),
    .pinIsOut (pinIsOut.port2),
    .nandOut  (nandP2All),
    .norOut   (unusedNor2All)
  );

  stw_pin_gate #(.WIDTH(6)) uGateP3P2 (
    .pinLvl   ({pinLvl.port3, pinLvl.port2[2:0]}),
    .pinIsOut ({pinIsOut.port3, pinIsOut.port2[2:0]}),
    .nandOut  (nandP3P2),
    .norOut   (unusedNor3P2)
  );

  // Source mux; purely gates so it works while the oscillator is stopped
  always_comb begin
    unique case (st_r.src)
      SRC_POR_ONLY:   selComb = 1'b0;
      SRC_NAND_P2LO:  selComb = nandP2Lo;
      SRC_NAND_P2ALL: selComb = nandP2All;
      SRC_NOR_P3:     selComb = norP3;
      SRC_NAND_P3:    selComb = nandP3;
      SRC_NOR_P3P0:   selComb = norP3P0;
      SRC_NAND_P3P0:  selComb = nandP3P0;
      SRC_NAND_P3P2:  selComb = nandP3P2;
    endcase
  end

  // Level XOR; recovery when the XOR output is low, never for POR-only
  assign cfgWake = (st_r.src != SRC_POR_ONLY) && !(selComb ^ st_r.level);
  // Either configured source ends stop mode
  assign stopWake = cfgWake | primaryWake;
  assign primarySrcSel = st_r.prim;

  // APB answer comes from flops
  assign apbRsp.pready  = st_r.ack;
  assign apbRsp.pslverr = st_r.err;
  assign apbRsp.prdata  = st_r.rdata;

  logic accessPh;
  logic doneEdge;
  logic hitCfg;
  logic hitPrim;
  logic hitStat;

  // Address decode on word index
  assign accessPh = apbReq.psel && apbReq.penable;
  assign doneEdge = accessPh && st_r.ack;
  assign hitCfg   = apbReq.paddr == (CFG_TWO_IDX << IDX_SHIFT);
  assign hitPrim  = apbReq.paddr == (PRIM_IDX << IDX_SHIFT);
  assign hitStat  = apbReq.paddr == (STAT_IDX << IDX_SHIFT);

  // Next state: one wait state per access, write lands at the pready edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.syncWake = {st_r.syncWake[0], stopWake};
    st_nxt.syncCfg  = {st_r.syncCfg[0], cfgWake};
    st_nxt.syncPrim = {st_r.syncPrim[0], primaryWake};
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    if (accessPh && !st_r.ack) begin
      st_nxt.ack   = 1'b1;
      st_nxt.err   = !(hitCfg || hitPrim || hitStat);
      st_nxt.rdata = ZERO_WORD;
      if (!apbReq.pwrite && hitPrim) begin
        st_nxt.rdata[PRIM_MSB:PRIM_LSB] = st_r.prim;
      end
      if (!apbReq.pwrite && hitStat) begin
        st_nxt.rdata[STAT_WAKE] = st_r.syncWake[1];
        st_nxt.rdata[STAT_CFG2] = st_r.syncCfg[1];
        st_nxt.rdata[STAT_PRIM] = st_r.syncPrim[1];
      end
    end
    // Reserved bits are dropped, whatever software writes
    if (doneEdge && apbReq.pwrite && hitCfg) begin
      st_nxt.src   = stw_src_t'(apbReq.pwdata[SRC_MSB:SRC_LSB]);
      st_nxt.level = apbReq.pwdata[LEVEL_BIT];
    end
    if (doneEdge && apbReq.pwrite && hitPrim) begin
      st_nxt.prim = apbReq.pwdata[PRIM_MSB:PRIM_LSB];
    end
  end

  // Register the state; synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r       <= '0;
      st_r.src   <= SRC_RST;
      st_r.level <= LEVEL_RST;
      st_r.prim  <= PRIM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking

  sequence cfgReadDone;
    doneEdge && !apbReq.pwrite && hitCfg;
  endsequence

  sequence primWriteDone;
    doneEdge && apbReq.pwrite && hitPrim;
  endsequence

  reset_clears_cfg_a: assert property (!nrst |=> (st_r.src == SRC_POR_ONLY && !st_r.level))
    else $error("config not cleared by reset");
  nor_select_a: assert property (disable iff (!nrst) (st_r.src == SRC_NOR_P3P0 && pinIsOut == '0)
    |-> selComb == !(|pinLvl.port3 || pinLvl.port0bit7 || pinLvl.port0bit0))
    else $error("nor source wrong");
  nand_select_a: assert property (disable iff (!nrst) (st_r.src == SRC_NAND_P3 && pinIsOut == '0)
    |-> selComb == !(&pinLvl.port3))
    else $error("nand source wrong");
  port2_select_a: assert property (disable iff (!nrst) (st_r.src == SRC_NAND_P2LO && pinIsOut == '0)
    |-> selComb == !(&pinLvl.port2[3:0]))
    else $error("port2 nand source wrong");
  level_xor_a: assert property (disable iff (!nrst) (st_r.src == SRC_NAND_P3P2 && pinIsOut == '0)
    |-> cfgWake == ((!(&{pinLvl.port3, pinLvl.port2[2:0]})) == st_r.level))
    else $error("recovery level not applied");
  out_pins_ignored_a: assert property (disable iff (!nrst) (st_r.src == SRC_NAND_P2ALL && &pinIsOut.port2)
    |-> !selComb)
    else $error("output pin took part");
  either_wakes_a: assert property (disable iff (!nrst) (primaryWake || cfgWake) |-> stopWake)
    else $error("wake event lost");
  cfg_write_only_a: assert property (disable iff (!nrst) cfgReadDone |-> apbRsp.prdata == ZERO_WORD)
    else $error("config readback not zero");
  prim_field_a: assert property (disable iff (!nrst) primWriteDone
    |=> primarySrcSel == $past(apbReq.pwdata[PRIM_MSB:PRIM_LSB]))
    else $error("primary field not stored");

endmodule : stw_wakeup_sel

// ---- verif/stw_pin_model.sv ----
// Behavioural port pins and primary wake source facing the selector
`timescale 1ns/10ps
module stw_pin_model (
  input  wire stw_pkg::stw_pins_t lvlSet,
  input  wire stw_pkg::stw_pins_t outSet,
  input  wire logic               primSet,
  output      stw_pkg::stw_pins_t pinLvl,
  output      stw_pkg::stw_pins_t pinIsOut,
  output logic                    primaryWake
);
  import stw_pkg::*;
  // Pins follow the bench directly, so changes land with no clock edge
  assign pinLvl      = lvlSet;
  assign pinIsOut    = outSet;
  assign primaryWake = primSet;
endmodule : stw_pin_model

// ---- verif/tb.sv ----
// Self-checking bench of the stop-mode wake-up source selector
`timescale 1ns/10ps
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, sn); end end
module tb;
  import stw_pkg::*;
  logic         sys_clk;
  logic         nrst        = 1'b0;
  stw_apb_req_t apbReq      = '0;
  stw_apb_rsp_t apbRsp;
  stw_pins_t    lvlSet      = '0;
  stw_pins_t    outSet      = '0;
  stw_pins_t    pinLvl;
  stw_pins_t    pinIsOut;
  logic         primSet     = 1'b0;
  logic         primaryWake;
  logic         stopWake;
  logic [2:0]   primarySrcSel;
  logic [31:0]  rdData;
  logic         rdErr;
  int           err_total   = 0;
  int           checks_done = 0;
  int           cycCnt      = 0;
  // Pin patterns: all high, all low, mixed; masks: none, partial, all out
  stw_pins_t    pats[3]     = '{13'h1fff, 13'h0000, 13'h1555};
  stw_pins_t    outs[3]     = '{13'h0000, 13'h0aaa, 13'h1fff};

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  stw_wakeup_sel u_stw_wakeup_sel (.sys_clk, .nrst, .apbReq, .apbRsp, .pinLvl, .pinIsOut,
                                   .primaryWake, .primarySrcSel, .stopWake);
  stw_pin_model  u_stw_pin_model (.lvlSet, .outSet, .primSet, .pinLvl, .pinIsOut, .primaryWake);

  // One APB transfer; waits for pready, then an idle cycle so drives never collide
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    @(posedge sys_clk);
    while (apbRsp.pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) err_total++;
    rdData = apbRsp.prdata;
    rdErr  = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge sys_clk);
  endtask : apb

  // Expected wake level; excluded pins read 1 for NAND and 0 for NOR
  function automatic logic expWake(input logic [2:0] c, input logic lv, input stw_pins_t p,
                                   input stw_pins_t o, input logic pw);
    stw_pins_t a;
    stw_pins_t r;
    logic      g;
    a = p | o;
    r = p & ~o;
    case (c)
      3'h1: g = ~&a.port2[3:0];
      3'h2: g = ~&a.port2;
      3'h3: g = ~|r.port3;
      3'h4: g = ~&a.port3;
      3'h5: g = ~|{r.port3, r.port0bit7, r.port0bit0};
      3'h6: g = ~&{a.port3, a.port0bit7, a.port0bit0};
      3'h7: g = ~&{a.port3, a.port2[2:0]};
      default: return pw;
    endcase
    return pw | (g == lv);
  endfunction : expWake

  task automatic t_reset;
    `CHK("wake", 1'b0, stopWake)
    `CHK("psel", 3'h0, primarySrcSel)
    apb(1'b0, 8'h34, 32'h0000_0000);
    `CHK("cfgrd", 32'h0000_0000, rdData)
    $display("test reset done");
  endtask : t_reset

  // Every code and level over pin patterns and exclusion masks, checked between edges
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      for (int lv = 0; lv < 2; lv++) begin
        apb(1'b1, 8'h34, {25'h0, lv[0], 1'b0, c[2:0], 2'b00});
        for (int i = 0; i < 9; i++) begin
          lvlSet <= pats[i % 3];
          outSet <= outs[i / 3];
          @(negedge sys_clk);
          `CHK("wake", expWake(c[2:0], lv[0], pats[i % 3], outs[i / 3], 1'b0), stopWake)
          @(posedge sys_clk);
        end
      end
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_primary;
    apb(1'b1, 8'h34, 32'h0000_0000);
    primSet <= 1'b1;
    @(negedge sys_clk);
    `CHK("wake", 1'b1, stopWake)
    @(posedge sys_clk);
    primSet <= 1'b0;
    apb(1'b1, 8'h2c, 32'h0000_001c);
    `CHK("psel", 3'h7, primarySrcSel)
    apb(1'b0, 8'h2c, 32'h0000_0000);
    `CHK("primrd", 32'h0000_001c, rdData)
    $display("test primary done");
  endtask : t_primary

  task automatic t_unmapped;
    apb(1'b0, 8'h3c, 32'h0000_0000);
    `CHK("slverr", 1'b1, rdErr)
    `CHK("badrd", 32'h0000_0000, rdData)
    $display("test unmapped done");
  endtask : t_unmapped

  // Status word follows the wake sources after the two-flop lag; config stays unreadable
  task automatic t_status;
    lvlSet <= 13'h0000;
    outSet <= 13'h0000;
    apb(1'b1, 8'h34, 32'h0000_004c);
    apb(1'b0, 8'h34, 32'h0000_0000);
    `CHK("cfgrd", 32'h0000_0000, rdData)
    primSet <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, 8'h38, 32'h0000_0000);
    `CHK("stat", 32'h0000_0007, rdData)
    `CHK("staterr", 1'b0, rdErr)
    primSet <= 1'b0;
    lvlSet  <= 13'h1fff;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, 8'h38, 32'h0000_0000);
    `CHK("stat", 32'h0000_0000, rdData)
    $display("test status done");
  endtask : t_status

  // Mid-run reset drops a live configuration back to POR-only
  task automatic t_midreset;
    lvlSet <= 13'h0000;
    outSet <= 13'h0000;
    apb(1'b1, 8'h34, 32'h0000_004c);
    apb(1'b1, 8'h2c, 32'h0000_001c);
    `CHK("wake", 1'b1, stopWake)
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    `CHK("wake", 1'b0, stopWake)
    `CHK("psel", 3'h0, primarySrcSel)
    apb(1'b0, 8'h2c, 32'h0000_0000);
    `CHK("primrd", 32'h0000_0000, rdData)
    $display("test midreset done");
  endtask : t_midreset

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycCnt <= cycCnt + 1;
    if (cycCnt == 8000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_codes();
    t_primary();
    t_status();
    t_midreset();
    t_unmapped();
    conclude();
  end
endmodule : tb
